/* File: include/clock_select_pkg.sv */
`default_nettype none
package clock_select_pkg;
   // ----------------------------------------
   // Bus and register map
   // ----------------------------------------
   localparam int AXI_ADDR_W = 8;
   localparam logic [AXI_ADDR_W-1:0] OFF_CTRL = 8'h00;
   localparam logic [AXI_ADDR_W-1:0] OFF_SEL = 8'h04;
   localparam logic [AXI_ADDR_W-1:0] OFF_DIV = 8'h08;
   localparam logic [AXI_ADDR_W-1:0] OFF_FREQ = 8'h0C;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------
   // Field layout
   // ----------------------------------------
   localparam int SRC_COUNT = 4;
   localparam int SRC_W = 2;
   localparam int PRE_W = 2;
   localparam int CTRL_RDY_LSB = 4;
   localparam int CTRL_EXT_EN_BIT = 2;
   localparam int CTRL_HRC_EN_BIT = 1;
   localparam int SEL_ACT_LSB = 6;
   localparam int SEL_REQ_LSB = 4;
   localparam int SEL_PRE_LSB = 0;

   // ----------------------------------------
   // Reset values and divider constants
   // ----------------------------------------
   localparam logic [7:0] CTRL_RESET = 8'h32;
   localparam logic [7:0] SEL_RESET = 8'h53;
   localparam logic [7:0] DIV_RESET = 8'h02;
   localparam logic [SRC_COUNT-1:0] RDY_RESET = CTRL_RESET[CTRL_RDY_LSB +: SRC_COUNT];
   localparam logic [7:0] DIV_PASS_MAX = 8'h01;
   localparam logic [7:0] PRESCALE_UNIT = 8'h01;
   localparam logic [PRE_W-1:0] PRE_NONE = 2'h0;

   // Nominal source rates in Hz
   localparam logic [31:0] NOM_INT_LOW_HZ = 32'h0000ABE0;   // 44 kHz
   localparam logic [31:0] NOM_EXT_LOW_HZ = 32'h00008000;   // 32.768 kHz
   localparam logic [31:0] NOM_INT_HIGH_HZ = 32'h01E84800;  // 32 MHz
   localparam logic [31:0] NOM_EXT_HIGH_MIN_HZ = 32'h003D0900; // 4 MHz
   localparam logic [31:0] NOM_EXT_HIGH_MAX_HZ = 32'h016E3600; // 24 MHz

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [SRC_W-1:0] {
      SRC_INT_LOW = 2'h0,
      SRC_INT_HIGH = 2'h1,
      SRC_EXT_LOW = 2'h2,
      SRC_EXT_HIGH = 2'h3
   } src_t;

   typedef struct packed {
      logic ext_osc_enable;
      logic int_high_rc_enable;
   } osc_enable_t;

   typedef struct packed {
      logic [7:0] cnt;
      logic tick;
   } div_state_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic aw_held;
      logic w_held;
      logic [AXI_ADDR_W-1:0] aw_addr;
      logic [7:0] w_byte;
      logic w_lane0;
      logic [SRC_COUNT-1:0] rdy_s1;
      logic [SRC_COUNT-1:0] rdy_s2;
      logic [SRC_COUNT-1:0] rdy_s3;
      logic [SRC_COUNT-1:0] rdy;
      logic [SRC_COUNT-1:0] tck_s1;
      logic [SRC_COUNT-1:0] tck_s2;
      logic [SRC_COUNT-1:0] tck_s3;
      logic [SRC_COUNT-1:0] tck;
      logic ext_en;
      logic hrc_en;
      src_t active;
      src_t requested;
      logic [PRE_W-1:0] prescale;
      logic [7:0] cpu_div;
      logic osc_tick;
      logic wdt_tick;
   } top_state_t;

   localparam top_state_t TOP_RESET = '{
      rdy_s1: RDY_RESET,
      rdy_s2: RDY_RESET,
      rdy_s3: RDY_RESET,
      rdy: RDY_RESET,
      ext_en: CTRL_RESET[CTRL_EXT_EN_BIT],
      hrc_en: CTRL_RESET[CTRL_HRC_EN_BIT],
      active: src_t'(SEL_RESET[SEL_ACT_LSB +: SRC_W]),
      requested: src_t'(SEL_RESET[SEL_REQ_LSB +: SRC_W]),
      prescale: SEL_RESET[SEL_PRE_LSB +: PRE_W],
      cpu_div: DIV_RESET,
      default: '0
   };
endpackage : clock_select_pkg
`default_nettype wire

/* File: hdl/clock_tick_divider.sv */
`timescale 1ns/1ps
`default_nettype none
module clock_tick_divider import clock_select_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic tick_in,
   input wire logic [7:0] factor,
   output logic tick_out
);
   div_state_t state_reg;
   div_state_t state_next;

   // Count input ticks, pulse once per factor
   always_comb begin
      state_next = state_reg;
      state_next.tick = 1'b0;
      if (factor <= DIV_PASS_MAX) begin
         state_next.tick = tick_in;
         state_next.cnt = '0;
      end else if (tick_in) begin
         if (state_reg.cnt >= factor - 8'h01) begin
            state_next.cnt = '0;
            state_next.tick = 1'b1;
         end else begin
            state_next.cnt = state_reg.cnt + 8'h01;
         end
      end
   end

   // State register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign tick_out = state_reg.tick;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_pass_through;
      @(posedge aclk) disable iff (!aresetn)
      (factor <= DIV_PASS_MAX) |-> ##1 (tick_out == $past(tick_in));
   endproperty
   a_pass_through: assert property (p_pass_through) else $error("undivided tick lost");

   property p_divide_hit;
      @(posedge aclk) disable iff (!aresetn)
      (factor > DIV_PASS_MAX && tick_in && state_reg.cnt == factor - 8'h01) |=> tick_out;
   endproperty
   a_divide_hit: assert property (p_divide_hit) else $error("divided tick missing");

   property p_no_spurious;
      @(posedge aclk) disable iff (!aresetn)
      tick_out |-> $past(tick_in);
   endproperty
   a_no_spurious: assert property (p_no_spurious) else $error("tick without input");
endmodule : clock_tick_divider
`default_nettype wire

/* File: hdl/system_clock_select.sv */
`timescale 1ns/1ps
`default_nettype none
module system_clock_select import clock_select_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [AXI_ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [AXI_ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [SRC_COUNT-1:0] osc_ready_pins,
   input wire logic [SRC_COUNT-1:0] osc_clock_pins,
   output osc_enable_t osc_enables,
   output src_t active_source,
   output logic osc_tick,
   output logic cpu_tick,
   output logic watchdog_tick
);
   // ----------------------------------------
   // State and helpers
   // ----------------------------------------
   top_state_t state_reg;
   top_state_t state_next;
   logic [SRC_COUNT-1:0] tck_edge;
   logic wr_fire;
   logic [7:0] ctrl_byte;
   logic [7:0] sel_byte;
   logic [7:0] pre_factor;
   logic [31:0] freq_hz;
   logic pre_tick;

   // Fast RC prescaler by 1, 2, 4 or 8
   clock_tick_divider u_prescale (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick_in(tck_edge[SRC_INT_HIGH]),
      .factor(pre_factor),
      .tick_out(pre_tick)
   );

   // CPU clock divider on the system clock
   clock_tick_divider u_cpu_div (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick_in(state_reg.osc_tick),
      .factor(state_reg.cpu_div),
      .tick_out(cpu_tick)
   );

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      state_next = state_reg;
      wr_fire = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
      pre_factor = PRESCALE_UNIT << state_reg.prescale;

      // Pin synchronisers, level moves when stages 2 and 3 agree
      state_next.rdy_s1 = osc_ready_pins;
      state_next.rdy_s2 = state_reg.rdy_s1;
      state_next.rdy_s3 = state_reg.rdy_s2;
      state_next.rdy = (state_reg.rdy_s2 & state_reg.rdy_s3) |
                       (state_reg.rdy & (state_reg.rdy_s2 | state_reg.rdy_s3));
      state_next.tck_s1 = osc_clock_pins;
      state_next.tck_s2 = state_reg.tck_s1;
      state_next.tck_s3 = state_reg.tck_s2;
      state_next.tck = (state_reg.tck_s2 & state_reg.tck_s3) |
                       (state_reg.tck & (state_reg.tck_s2 | state_reg.tck_s3));
      tck_edge = state_next.tck & ~state_reg.tck;

      // Selected source tick, prescaled when fast RC
      if (state_reg.active == SRC_INT_HIGH) begin
         state_next.osc_tick = pre_tick;
      end else begin
         state_next.osc_tick = tck_edge[state_reg.active];
      end
      state_next.wdt_tick = tck_edge[SRC_INT_LOW];

      // Source switch gated by the target ready flag
      if (state_reg.requested != state_reg.active &&
          state_reg.rdy[state_reg.requested]) begin
         state_next.active = state_reg.requested;
      end

      // Register views
      ctrl_byte = '0;
      ctrl_byte[CTRL_RDY_LSB +: SRC_COUNT] = state_reg.rdy;
      ctrl_byte[CTRL_EXT_EN_BIT] = state_reg.ext_en;
      ctrl_byte[CTRL_HRC_EN_BIT] = state_reg.hrc_en;
      sel_byte = '0;
      sel_byte[SEL_ACT_LSB +: SRC_W] = state_reg.active;
      sel_byte[SEL_REQ_LSB +: SRC_W] = state_reg.requested;
      sel_byte[SEL_PRE_LSB +: PRE_W] = state_reg.prescale;

      // Nominal rate of the system clock
      case (state_reg.active)
         SRC_INT_LOW: freq_hz = NOM_INT_LOW_HZ;
         SRC_INT_HIGH: freq_hz = NOM_INT_HIGH_HZ >> state_reg.prescale;
         SRC_EXT_LOW: freq_hz = NOM_EXT_LOW_HZ;
         default: freq_hz = NOM_EXT_HIGH_MAX_HZ;
      endcase

      // Write channels accepted in either order
      if (awvalid && state_reg.awready) begin
         state_next.aw_held = 1'b1;
         state_next.aw_addr = awaddr;
      end
      if (wvalid && state_reg.wready) begin
         state_next.w_held = 1'b1;
         state_next.w_byte = wdata[7:0];
         state_next.w_lane0 = wstrb[0];
      end
      if (state_reg.bvalid && bready) begin
         state_next.bvalid = 1'b0;
      end

      // Register write once address and data are both held
      if (wr_fire) begin
         state_next.aw_held = 1'b0;
         state_next.w_held = 1'b0;
         state_next.bvalid = 1'b1;
         state_next.bresp = RESP_OKAY;
         if (state_reg.aw_addr == OFF_CTRL) begin
            if (state_reg.w_lane0) begin
               state_next.ext_en = state_reg.w_byte[CTRL_EXT_EN_BIT];
               state_next.hrc_en = state_reg.w_byte[CTRL_HRC_EN_BIT];
            end
         end else if (state_reg.aw_addr == OFF_SEL) begin
            if (state_reg.w_lane0) begin
               state_next.requested = src_t'(state_reg.w_byte[SEL_REQ_LSB +: SRC_W]);
               state_next.prescale = state_reg.w_byte[SEL_PRE_LSB +: PRE_W];
            end
         end else if (state_reg.aw_addr == OFF_DIV) begin
            if (state_reg.w_lane0) begin
               state_next.cpu_div = state_reg.w_byte;
            end
         end else if (state_reg.aw_addr == OFF_FREQ) begin
            state_next.bresp = RESP_OKAY; // Read-only, write ignored
         end else begin
            state_next.bresp = RESP_SLVERR;
         end
      end
      state_next.awready = !state_next.aw_held;
      state_next.wready = !state_next.w_held;

      // Read channel, answer on the same edge that takes the address
      if (state_reg.rvalid && rready) begin
         state_next.rvalid = 1'b0;
      end
      if (arvalid && state_reg.arready) begin
         state_next.rvalid = 1'b1;
         state_next.rresp = RESP_OKAY;
         if (araddr == OFF_CTRL) begin
            state_next.rdata = 32'(ctrl_byte);
         end else if (araddr == OFF_SEL) begin
            state_next.rdata = 32'(sel_byte);
         end else if (araddr == OFF_DIV) begin
            state_next.rdata = 32'(state_reg.cpu_div);
         end else if (araddr == OFF_FREQ) begin
            state_next.rdata = freq_hz;
         end else begin
            state_next.rdata = '0;
            state_next.rresp = RESP_SLVERR;
         end
      end
      state_next.arready = !state_next.rvalid;
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= TOP_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from the state register
   assign awready = state_reg.awready;
   assign wready = state_reg.wready;
   assign bvalid = state_reg.bvalid;
   assign bresp = state_reg.bresp;
   assign arready = state_reg.arready;
   assign rvalid = state_reg.rvalid;
   assign rresp = state_reg.rresp;
   assign rdata = state_reg.rdata;
   assign osc_enables.ext_osc_enable = state_reg.ext_en;
   assign osc_enables.int_high_rc_enable = state_reg.hrc_en;
   assign active_source = state_reg.active;
   assign osc_tick = state_reg.osc_tick;
   assign watchdog_tick = state_reg.wdt_tick;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_ready_follow;
      @(posedge aclk) disable iff (!aresetn)
      (state_reg.rdy_s2 == state_reg.rdy_s3) |=> (state_reg.rdy == $past(state_reg.rdy_s3));
   endproperty
   a_ready_follow: assert property (p_ready_follow) else $error("ready flag stale");

   property p_ext_enable_write;
      @(posedge aclk) disable iff (!aresetn)
      (wr_fire && state_reg.aw_addr == OFF_CTRL && state_reg.w_lane0) |=>
         (osc_enables.ext_osc_enable == $past(state_reg.w_byte[CTRL_EXT_EN_BIT]));
   endproperty
   a_ext_enable_write: assert property (p_ext_enable_write) else $error("ext enable");

   property p_hrc_enable_write;
      @(posedge aclk) disable iff (!aresetn)
      (wr_fire && state_reg.aw_addr == OFF_CTRL && state_reg.w_lane0) |=>
         (osc_enables.int_high_rc_enable == $past(state_reg.w_byte[CTRL_HRC_EN_BIT]));
   endproperty
   a_hrc_enable_write: assert property (p_hrc_enable_write) else $error("rc enable");

   property p_status_read;
      @(posedge aclk) disable iff (!aresetn)
      (arvalid && arready && araddr == OFF_SEL) |=>
         (rvalid && rdata[SEL_ACT_LSB +: SRC_W] == $past(active_source));
   endproperty
   a_status_read: assert property (p_status_read) else $error("status read wrong");

   property p_switch_needs_ready;
      @(posedge aclk) disable iff (!aresetn)
      (state_next.active != state_reg.active) |-> state_reg.rdy[state_next.active];
   endproperty
   a_switch_needs_ready: assert property (p_switch_needs_ready) else $error("not ready");

   property p_switch_taken;
      @(posedge aclk) disable iff (!aresetn)
      (state_reg.requested != state_reg.active && state_reg.rdy[state_reg.requested]) |=>
         (active_source == $past(state_reg.requested));
   endproperty
   a_switch_taken: assert property (p_switch_taken) else $error("switch missed");

   property p_keep_enables;
      @(posedge aclk) disable iff (!aresetn)
      (state_next.active != state_reg.active && !wr_fire) |=>
         ($stable(osc_enables));
   endproperty
   a_keep_enables: assert property (p_keep_enables) else $error("source stopped");

   property p_prescale_pass;
      @(posedge aclk) disable iff (!aresetn)
      (state_reg.active == SRC_INT_HIGH && state_reg.prescale == PRE_NONE &&
       tck_edge[SRC_INT_HIGH]) ##1 (state_reg.active == SRC_INT_HIGH) |=> osc_tick;
   endproperty
   a_prescale_pass: assert property (p_prescale_pass) else $error("prescale tick");

   property p_wdt_tick;
      @(posedge aclk) disable iff (!aresetn)
      tck_edge[SRC_INT_LOW] |=> watchdog_tick;
   endproperty
   a_wdt_tick: assert property (p_wdt_tick) else $error("watchdog tick lost");

   property p_bvalid_hold;
      @(posedge aclk) disable iff (!aresetn)
      (bvalid && !bready) |=> (bvalid && $stable(bresp));
   endproperty
   a_bvalid_hold: assert property (p_bvalid_hold) else $error("bvalid dropped");

   property p_rvalid_hold;
      @(posedge aclk) disable iff (!aresetn)
      (rvalid && !rready) |=> (rvalid && $stable(rdata) && $stable(rresp));
   endproperty
   a_rvalid_hold: assert property (p_rvalid_hold) else $error("rvalid dropped");

   property p_arready_refuse;
      @(posedge aclk) disable iff (!aresetn)
      rvalid |-> !arready;
   endproperty
   a_arready_refuse: assert property (p_arready_refuse) else $error("read taken while busy");

   property p_ready_read;
      @(posedge aclk) disable iff (!aresetn)
      (arvalid && arready && araddr == OFF_CTRL) |=>
         (rdata[CTRL_RDY_LSB +: SRC_COUNT] == $past(state_reg.rdy));
   endproperty
   a_ready_read: assert property (p_ready_read) else $error("ready flags read wrong");

   property p_request_write;
      @(posedge aclk) disable iff (!aresetn)
      (wr_fire && state_reg.aw_addr == OFF_SEL && state_reg.w_lane0) |=>
         (state_reg.requested == $past(state_reg.w_byte[SEL_REQ_LSB +: SRC_W]));
   endproperty
   a_request_write: assert property (p_request_write) else $error("request lost");

   property p_prescale_write;
      @(posedge aclk) disable iff (!aresetn)
      (wr_fire && state_reg.aw_addr == OFF_SEL && state_reg.w_lane0) |=>
         (state_reg.prescale == $past(state_reg.w_byte[SEL_PRE_LSB +: PRE_W]));
   endproperty
   a_prescale_write: assert property (p_prescale_write) else $error("prescale lost");

   property p_divide_write;
      @(posedge aclk) disable iff (!aresetn)
      (wr_fire && state_reg.aw_addr == OFF_DIV && state_reg.w_lane0) |=>
         (state_reg.cpu_div == $past(state_reg.w_byte));
   endproperty
   a_divide_write: assert property (p_divide_write) else $error("divide lost");

   property p_ext_low_rate;
      @(posedge aclk) disable iff (!aresetn)
      (arvalid && arready && araddr == OFF_FREQ && active_source == SRC_EXT_LOW) |=>
         (rdata == NOM_EXT_LOW_HZ);
   endproperty
   a_ext_low_rate: assert property (p_ext_low_rate) else $error("rate read wrong");

   c_switch_ext_high: cover property (@(posedge aclk) disable iff (!aresetn)
      $changed(active_source) && active_source == SRC_EXT_HIGH);
   c_prescale_eight: cover property (@(posedge aclk) disable iff (!aresetn)
      osc_tick && active_source == SRC_INT_HIGH && state_reg.prescale == 2'h3);
   c_write_resp: cover property (@(posedge aclk) disable iff (!aresetn)
      bvalid && bready);
   c_cpu_divide: cover property (@(posedge aclk) disable iff (!aresetn)
      cpu_tick && state_reg.cpu_div > DIV_RESET);
   c_switch_blocked: cover property (@(posedge aclk) disable iff (!aresetn)
      state_reg.requested != state_reg.active && !state_reg.rdy[state_reg.requested]);
endmodule : system_clock_select
`default_nettype wire

/* File: verification/system_clock_select_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module system_clock_select_tb import clock_select_pkg::*;;
   logic aclk;
   logic aresetn;
   logic [7:0] awaddr;
   logic [7:0] araddr;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp;
   logic [1:0] rresp;
   logic [3:0] osc_ready_pins;
   logic [3:0] osc_clock_pins;
   osc_enable_t osc_enables;
   src_t active_source;
   logic osc_tick, cpu_tick, watchdog_tick;
   int error_cnt = 0, n_checks = 0, osc_cnt = 0, cpu_cnt = 0, wd_cnt = 0, i;
   // Nominal rate per source code, fast RC at its divide-by-eight setting
   logic [31:0] nom_hz [4] = '{NOM_INT_LOW_HZ, NOM_INT_HIGH_HZ / 32'h8, NOM_EXT_LOW_HZ, NOM_EXT_HIGH_MAX_HZ};

   system_clock_select dut_u (
      .aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .osc_ready_pins(osc_ready_pins), .osc_clock_pins(osc_clock_pins),
      .osc_enables(osc_enables), .active_source(active_source),
      .osc_tick(osc_tick), .cpu_tick(cpu_tick), .watchdog_tick(watchdog_tick)
   );

   // ----------------------------------------
   // Clock and tick counters
   // ----------------------------------------
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // Count one-cycle pulses of each tick output, between edges
   always @(negedge aclk) begin
      if (osc_tick === 1'b1)
         osc_cnt <= osc_cnt + 1;
      if (cpu_tick === 1'b1)
         cpu_cnt <= cpu_cnt + 1;
      if (watchdog_tick === 1'b1)
         wd_cnt <= wd_cnt + 1;
   end

   // ----------------------------------------
   // Reporting
   // ----------------------------------------
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %0h seen %0h", what, exp, got);
      end
   endtask : check

   task automatic complete_run;
      $display("Checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : complete_run

   task automatic timed_out(input string what);
      error_cnt++;
      $display("Error %s expected answer seen timeout", what);
      complete_run();
   endtask : timed_out

   // ----------------------------------------
   // Register bus tasks
   // ----------------------------------------
   task automatic axi_write(input logic [7:0] addr, input logic [31:0] data,
         input logic [3:0] strb, input logic [1:0] exp_resp);
      bit aw_hs, w_hs, b_hs;
      logic [1:0] got_resp;
      int n;
      @(posedge aclk);
      awaddr <= addr;
      wdata <= data;
      wstrb <= strb;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // Sample between edges, release on the edge that takes each channel
      for (n = 0; n < 100; n++) begin
         @(negedge aclk);
         aw_hs = awvalid && awready === 1'b1;
         w_hs = wvalid && wready === 1'b1;
         b_hs = bvalid === 1'b1;
         got_resp = bresp;
         @(posedge aclk);
         if (aw_hs)
            awvalid <= 1'b0;
         if (w_hs)
            wvalid <= 1'b0;
         if (b_hs) begin
            check("write response", 32'(exp_resp), 32'(got_resp));
            bready <= 1'b0;
            break;
         end
      end
      if (n == 100)
         timed_out("write");
   endtask : axi_write

   task automatic axi_read(input logic [7:0] addr, input logic [31:0] exp_data,
         input logic [1:0] exp_resp);
      bit ar_hs, r_hs;
      logic [31:0] got_data;
      logic [1:0] got_resp;
      int n;
      @(posedge aclk);
      araddr <= addr;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(negedge aclk);
         ar_hs = arvalid && arready === 1'b1;
         r_hs = rvalid === 1'b1;
         got_data = rdata;
         got_resp = rresp;
         @(posedge aclk);
         if (ar_hs)
            arvalid <= 1'b0;
         if (r_hs) begin
            check($sformatf("read data %0h", addr), exp_data, got_data);
            check($sformatf("read response %0h", addr), 32'(exp_resp), 32'(got_resp));
            rready <= 1'b0;
            break;
         end
      end
      if (n == 100)
         timed_out("read");
   endtask : axi_read

   // Slow source edges, four cycles high and four low, then let ticks land
   task automatic measure(input logic [3:0] mask, input int n, input int exp_osc,
         input int exp_cpu);
      int o0, c0, w0;
      o0 = osc_cnt;
      c0 = cpu_cnt;
      w0 = wd_cnt;
      repeat (n) begin
         osc_clock_pins <= mask;
         repeat (4) @(posedge aclk);
         osc_clock_pins <= 4'h0;
         repeat (4) @(posedge aclk);
      end
      repeat (12) @(posedge aclk);
      check("osc ticks", 32'(exp_osc), 32'(osc_cnt - o0));
      check("cpu ticks", 32'(exp_cpu), 32'(cpu_cnt - c0));
      check("watchdog ticks", mask[0] ? 32'(n) : 32'h0, 32'(wd_cnt - w0));
   endtask : measure

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'h0;
      osc_ready_pins = 4'h3;
      osc_clock_pins = 4'h0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      // Reset state
      axi_read(OFF_CTRL, 32'h32, RESP_OKAY);
      axi_read(OFF_SEL, 32'h53, RESP_OKAY);
      axi_read(OFF_DIV, 32'h02, RESP_OKAY);
      axi_read(OFF_FREQ, nom_hz[SRC_INT_HIGH], RESP_OKAY);
      check("enables", 32'h1, 32'(osc_enables));
      check("active", 32'(SRC_INT_HIGH), 32'(active_source));
      // Enable bits set and clear, ready and reserved bits read only
      axi_write(OFF_CTRL, 32'hFF, 4'hF, RESP_OKAY);
      axi_read(OFF_CTRL, 32'h36, RESP_OKAY);
      check("enables", 32'h3, 32'(osc_enables));
      axi_write(OFF_CTRL, 32'h00, 4'hF, RESP_OKAY);
      axi_read(OFF_CTRL, 32'h30, RESP_OKAY);
      check("enables", 32'h0, 32'(osc_enables));
      axi_write(OFF_CTRL, 32'h02, 4'h0, RESP_OKAY);
      axi_read(OFF_CTRL, 32'h30, RESP_OKAY);
      axi_write(OFF_CTRL, 32'h02, 4'hF, RESP_OKAY);
      // Ready flags follow the pins
      for (i = 0; i < 16; i++) begin
         osc_ready_pins <= 4'(i);
         repeat (8) @(posedge aclk);
         axi_read(OFF_CTRL, {24'h0, 4'(i), 4'h2}, RESP_OKAY);
      end
      osc_ready_pins <= 4'h3;
      repeat (8) @(posedge aclk);
      // Request an unready source, then make it ready
      axi_write(OFF_SEL, 32'hE3, 4'hF, RESP_OKAY);
      repeat (8) @(posedge aclk);
      check("active", 32'(SRC_INT_HIGH), 32'(active_source));
      axi_read(OFF_SEL, 32'h63, RESP_OKAY);
      osc_ready_pins <= 4'h7;
      repeat (8) @(posedge aclk);
      check("active", 32'(SRC_EXT_LOW), 32'(active_source));
      axi_read(OFF_SEL, 32'hA3, RESP_OKAY);
      check("enables", 32'h1, 32'(osc_enables));
      // Every request code with all sources ready
      osc_ready_pins <= 4'hF;
      for (i = 0; i < 4; i++) begin
         axi_write(OFF_SEL, {24'h0, ~2'(i), 2'(i), 4'h3}, 4'hF, RESP_OKAY);
         repeat (8) @(posedge aclk);
         check("active", 32'(i), 32'(active_source));
         axi_read(OFF_SEL, {24'h0, 2'(i), 2'(i), 4'h3}, RESP_OKAY);
         axi_read(OFF_FREQ, nom_hz[i], RESP_OKAY);
         check("enables", 32'h1, 32'(osc_enables));
      end
      // Unmapped and misaligned places
      axi_write(8'h10, 32'h55, 4'hF, RESP_SLVERR);
      axi_read(8'h10, 32'h0, RESP_SLVERR);
      axi_read(8'h01, 32'h0, RESP_SLVERR);
      // Slow RC as system source, each small divide factor
      axi_write(OFF_SEL, 32'h03, 4'hF, RESP_OKAY);
      repeat (8) @(posedge aclk);
      for (i = 0; i < 4; i++) begin
         axi_write(OFF_DIV, 32'(i), 4'hF, RESP_OKAY);
         axi_read(OFF_DIV, 32'(i), RESP_OKAY);
         measure(4'h1, 12, 12, (i < 2) ? 12 : 12 / i);
      end
      // Fast RC prescaler, every setting
      // Divide by two keeps the undivided fast RC under the CPU limit
      axi_write(OFF_DIV, 32'h2, 4'hF, RESP_OKAY);
      for (i = 0; i < 4; i++) begin
         axi_write(OFF_SEL, {24'h0, 4'h1, 2'h0, 2'(i)}, 4'hF, RESP_OKAY);
         repeat (8) @(posedge aclk);
         axi_read(OFF_FREQ, NOM_INT_HIGH_HZ >> i, RESP_OKAY);
         measure(4'h2, 16, 16 >> i, 8 >> i);
      end
      complete_run();
   end
endmodule : system_clock_select_tb
`default_nettype wire
